// ==== hdl/acu_pkg.sv ====
package acu_pkg;
    localparam int unsigned WORD_W      = 16;
    localparam int unsigned BYTE_W      = 8;
    localparam int unsigned DIGIT_W     = 4;
    localparam int unsigned NUM_DIGITS  = 4;
    localparam int unsigned MAX_CHARS   = 16;
    localparam int unsigned MAX_WORDS   = 8;
    localparam int unsigned CNT_W       = 5;
    localparam int unsigned WIDX_W      = 3;
    localparam logic [3:0]  DIGIT_MAX   = 4'h9;
    localparam logic [15:0] ENC_SRC_MAX = 16'h270F;
    localparam logic [15:0] WORD_ZERO   = 16'h0000;

    typedef struct packed {
        logic [MAX_CHARS*BYTE_W-1:0] chars;
        logic [CNT_W-1:0]            count;
    } acu_str_t;

    typedef struct packed {
        logic                        we;
        logic [WIDX_W-1:0]           idx;
        logic [1:0]                  byte_en;
        logic [WORD_W-1:0]           data;
    } acu_wr_t;

    typedef struct packed {
        logic                        we;
        logic [WORD_W-1:0]           data;
    } acu_word_t;
endpackage

// ==== hdl/acu_bcd_digit.sv ====
`timescale 1ns/100ps
module acu_bcd_digit
(
    input  wire logic [15:0] value_i,
    input  wire logic [15:0] weight_i,
    output logic      [3:0]  digit_o,
    output logic      [15:0] rest_o
);
    // Repeated subtraction, at most nine steps, no divider needed
    always_comb
    begin
        digit_o = 4'h0;
        rest_o  = value_i;
        for (int k = 0; k < 9; k++)
        begin
            if (rest_o >= weight_i)
            begin
                rest_o  = rest_o - weight_i;
                digit_o = digit_o + 4'h1;
            end
        end
    end
endmodule

// ==== hdl/acu_top.sv ====
`timescale 1ns/100ps
// Operation
// [RL1] The packer writes character ASCII codes into consecutive words, first of a pair low byte, second high byte.
// [RL2] The packer writes only bytes of converted characters and leaves later bytes and words untouched.
// [RL3] The packer takes strings of up to 16 characters, at most eight words.
// [RL4] The decoder reads four BCD digits and writes the binary value, output ON.
// [RL5] A nibble above 9 blocks the decoder write, output stays OFF and the fault flag sets.
// [RL6] The encoder writes four packed BCD digits of the binary source, output ON.
// [RL7] A signed source below 0 or above 9999 blocks the encoder write, output OFF, fault flag set.
// [RL8] The fault flag stays set until the program clears it; success never clears it.
// [RL9] With enable OFF nothing is converted, nothing written, flag unchanged, output OFF.
module acu_top
(
    input  wire logic               sys_clk_i,
    input  wire logic               rst_i,
    input  wire logic               pack_en_i,
    input  wire acu_pkg::acu_str_t  pack_str_i,
    input  wire logic               dec_en_i,
    input  wire logic [15:0]        dec_src_i,
    input  wire logic               enc_en_i,
    input  wire logic [15:0]        enc_src_i,
    input  wire logic               fault_clr_i,
    output acu_pkg::acu_wr_t        pack_wr_o,
    output logic                    pack_ok_o,
    output acu_pkg::acu_word_t      dec_wr_o,
    output logic                    dec_ok_o,
    output acu_pkg::acu_word_t      enc_wr_o,
    output logic                    enc_ok_o,
    output logic                    instruction_fault_flag_o
);
    // ****************************************
    // Character packer
    // ****************************************
    typedef enum {PK_IDLE, PK_RUN, PK_DONE} acu_pk_state_t;
    acu_pk_state_t                   pk_state;
    acu_pk_state_t                   next_pk_state;
    logic [acu_pkg::WIDX_W-1:0]      pk_idx;
    logic [acu_pkg::WIDX_W-1:0]      next_pk_idx;
    acu_pkg::acu_str_t               pk_str;
    acu_pkg::acu_str_t               next_pk_str;
    acu_pkg::acu_wr_t                pk_wr;
    acu_pkg::acu_wr_t                next_pk_wr;
    logic [acu_pkg::CNT_W-1:0]       pk_lo;
    logic [acu_pkg::CNT_W-1:0]       pk_cnt;

    // Count clipped so a longer string never runs past eight words
    assign pk_cnt = (pack_str_i.count > 5'(acu_pkg::MAX_CHARS))
                  ? 5'(acu_pkg::MAX_CHARS) : pack_str_i.count; // [RL3]
    assign pk_lo  = {1'b0, pk_idx, 1'b0};

    always_comb
    begin
        next_pk_state = pk_state;
        next_pk_idx   = pk_idx;
        next_pk_str   = pk_str;
        next_pk_wr    = '0;
        case (pk_state)
            PK_IDLE:
            begin
                if (pack_en_i)
                begin
                    next_pk_str       = pack_str_i;
                    next_pk_str.count = pk_cnt;
                    next_pk_idx       = '0;
                    next_pk_state     = (pk_cnt == '0) ? PK_DONE : PK_RUN;
                end
            end
            PK_RUN:
            begin
                if (!pack_en_i)
                    next_pk_state = PK_IDLE; // [RL9]
                else
                begin
                    next_pk_wr.we  = 1'b1;
                    next_pk_wr.idx = pk_idx;
                    // First char low byte, second high byte
                    next_pk_wr.data[7:0] =
                        pk_str.chars[pk_lo*acu_pkg::BYTE_W +: 8]; // [RL1]
                    next_pk_wr.data[15:8] =
                        pk_str.chars[(pk_lo+5'h01)*acu_pkg::BYTE_W +: 8];
                    next_pk_wr.byte_en[0] = 1'b1;
                    // High lane only if a second char exists
                    next_pk_wr.byte_en[1] =
                        (pk_lo + 5'h01) < pk_str.count; // [RL2]
                    if ((pk_lo + 5'h02) >= pk_str.count)
                        next_pk_state = PK_DONE; // [RL2]
                    else
                        next_pk_idx = pk_idx + 3'h1;
                end
            end
            PK_DONE:
            begin
                if (!pack_en_i)
                    next_pk_state = PK_IDLE;
            end
            default:
                next_pk_state = PK_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            pk_state <= PK_IDLE;
            pk_idx   <= '0;
            pk_str   <= '0;
            pk_wr    <= '0;
        end
        else
        begin
            pk_state <= next_pk_state;
            pk_idx   <= next_pk_idx;
            pk_str   <= next_pk_str;
            pk_wr    <= next_pk_wr;
        end
    end

    assign pack_wr_o = pk_wr;
    assign pack_ok_o = (pk_state == PK_DONE) && pack_en_i; // [RL9]

    // ****************************************
    // Decimal to word decoder
    // ****************************************
    logic        dec_bad;
    logic [15:0] dec_val;

    always_comb
    begin
        dec_bad = 1'b0;
        dec_val = acu_pkg::WORD_ZERO;
        for (int d = acu_pkg::NUM_DIGITS - 1; d >= 0; d--)
        begin
            if (dec_src_i[d*4 +: 4] > acu_pkg::DIGIT_MAX)
                dec_bad = 1'b1; // [RL5]
            dec_val = 16'(dec_val * 16'd10) + 16'(dec_src_i[d*4 +: 4]); // [RL4]
        end
    end

    // ****************************************
    // Decimal digit encoder
    // ****************************************
    logic        enc_bad;
    logic [15:0] enc_bcd;
    logic [15:0] rest [0:4];
    logic [15:0] weight [0:3];

    assign weight[0] = 16'h03E8;
    assign weight[1] = 16'h0064;
    assign weight[2] = 16'h000A;
    assign weight[3] = 16'h0001;
    assign rest[0]   = enc_src_i;
    // Signed test: bit 15 set means negative
    assign enc_bad   = enc_src_i[15]
                     || (enc_src_i > acu_pkg::ENC_SRC_MAX); // [RL7]

    for (genvar g = 0; g < 4; g++)
    begin : g_dig
        acu_bcd_digit u_dig
        (
            .value_i  (rest[g]),
            .weight_i (weight[g]),
            .digit_o  (enc_bcd[(3-g)*4 +: 4]),
            .rest_o   (rest[g+1])
        );
    end

    // ****************************************
    // Results and fault flag
    // ****************************************
    acu_pkg::acu_word_t dec_wr;
    acu_pkg::acu_word_t next_dec_wr;
    acu_pkg::acu_word_t enc_wr;
    acu_pkg::acu_word_t next_enc_wr;
    logic               dec_ok;
    logic               next_dec_ok;
    logic               enc_ok;
    logic               next_enc_ok;
    logic               fault;
    logic               next_fault;

    always_comb
    begin
        next_dec_wr      = '0;
        next_enc_wr      = '0;
        next_dec_ok      = 1'b0;
        next_enc_ok      = 1'b0;
        next_fault       = fault;
        next_dec_wr.data = dec_wr.data;
        next_enc_wr.data = enc_wr.data;
        if (fault_clr_i)
            next_fault = 1'b0; // [RL8]
        if (dec_en_i)
        begin
            if (dec_bad)
                next_fault = 1'b1; // [RL5]
            else
            begin
                next_dec_wr.we   = 1'b1; // [RL4]
                next_dec_wr.data = dec_val;
                next_dec_ok      = 1'b1;
            end
        end
        if (enc_en_i)
        begin
            if (enc_bad)
                next_fault = 1'b1; // [RL7]
            else
            begin
                next_enc_wr.we   = 1'b1; // [RL6]
                next_enc_wr.data = enc_bcd;
                next_enc_ok      = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            dec_wr <= '0;
            enc_wr <= '0;
            dec_ok <= 1'b0;
            enc_ok <= 1'b0;
            fault  <= 1'b0;
        end
        else
        begin
            dec_wr <= next_dec_wr;
            enc_wr <= next_enc_wr;
            dec_ok <= next_dec_ok;
            enc_ok <= next_enc_ok;
            fault  <= next_fault;
        end
    end

    // Ok drops with enable so output is never ON while input is OFF
    assign dec_wr_o = dec_wr;
    assign enc_wr_o = enc_wr;
    assign dec_ok_o = dec_ok && dec_en_i; // [RL9]
    assign enc_ok_o = enc_ok && enc_en_i; // [RL9]
    assign instruction_fault_flag_o = fault;
endmodule

// ==== testbench/acu_dst_mem.sv ====
`timescale 1ns/100ps
// ****************************************
// Destination table behind the packer
// ****************************************
module acu_dst_mem
(
    input  wire logic             sys_clk_i,
    input  wire logic             fill_i,
    input  wire acu_pkg::acu_wr_t wr_i,
    output logic [15:0]           mem_o [8]
);
    // Preset lets the bench spot bytes that were written by mistake
    always_ff @(posedge sys_clk_i)
    begin
        for (int k = 0; k < 8; k++)
        begin
            if (fill_i)
                mem_o[k] <= 16'hEEEE;
        end
        if (wr_i.we && wr_i.byte_en[0])
            mem_o[wr_i.idx][7:0] <= wr_i.data[7:0];
        if (wr_i.we && wr_i.byte_en[1])
            mem_o[wr_i.idx][15:8] <= wr_i.data[15:8];
    end
endmodule

// ==== testbench/acu_chk_sva.sv ====
`timescale 1ns/100ps
// ****************************************
// Port checker
// ****************************************
module acu_chk
(
    input wire logic               sys_clk_i,
    input wire logic               rst_i,
    input wire logic               pack_en_i,
    input wire acu_pkg::acu_str_t  pack_str_i,
    input wire logic               dec_en_i,
    input wire logic [15:0]        dec_src_i,
    input wire logic               enc_en_i,
    input wire logic [15:0]        enc_src_i,
    input wire logic               fault_clr_i,
    input wire acu_pkg::acu_wr_t   pack_wr_o,
    input wire logic               pack_ok_o,
    input wire acu_pkg::acu_word_t dec_wr_o,
    input wire logic               dec_ok_o,
    input wire acu_pkg::acu_word_t enc_wr_o,
    input wire logic               enc_ok_o,
    input wire logic               instruction_fault_flag_o
);
    logic [15:0] dbin;
    logic [15:0] ebcd;
    logic        dbad;
    logic        ebad;
    always_comb
    begin
        dbin = 16'(dec_src_i[15:12] * 1000 + dec_src_i[11:8] * 100
                   + dec_src_i[7:4] * 10 + dec_src_i[3:0]);
        ebcd = {4'(enc_src_i / 1000), 4'(enc_src_i / 100 % 10),
                4'(enc_src_i / 10 % 10), 4'(enc_src_i % 10)};
        dbad = 1'b0;
        for (int i = 0; i < 4; i++)
            dbad = dbad | (dec_en_i && (dec_src_i[4*i+:4] > 4'h9));
        ebad = enc_en_i && (enc_src_i > 16'h270F);
    end
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    chk_dec_value: assert property (dec_en_i && !dbad |=> dec_wr_o.we
        && dec_ok_o == dec_en_i && dec_wr_o.data == $past(dbin))
        else $error("decoder result wrong");
    chk_dec_block: assert property (dbad |=> !dec_wr_o.we && !dec_ok_o
        && instruction_fault_flag_o) else $error("decoder not blocked");
    chk_enc_value: assert property (enc_en_i && !ebad |=> enc_wr_o.we
        && enc_ok_o == enc_en_i && enc_wr_o.data == $past(ebcd))
        else $error("encoder result wrong");
    chk_enc_block: assert property (ebad |=> !enc_wr_o.we && !enc_ok_o
        && instruction_fault_flag_o) else $error("encoder not blocked");
    chk_flag_hold: assert property (instruction_fault_flag_o
        && !fault_clr_i |=> instruction_fault_flag_o)
        else $error("fault flag dropped");
    chk_flag_cause: assert property ($rose(instruction_fault_flag_o)
        |-> $past(dbad || ebad)) else $error("fault flag without cause");
    chk_idle_quiet: assert property (!dec_en_i && !enc_en_i && !pack_en_i
        |=> !dec_wr_o.we && !enc_wr_o.we && !pack_ok_o && !dec_ok_o
        && !enc_ok_o && !pack_wr_o.we)
        else $error("idle unit active");
    chk_pack_step: assert property (pack_wr_o.we ##1 pack_wr_o.we
        |-> pack_wr_o.idx == 3'($past(pack_wr_o.idx) + 3'h1))
        else $error("packer words not consecutive");
    chk_pack_first: assert property ($rose(pack_en_i)
        && pack_str_i.count != 5'h00 |-> ##2 pack_wr_o.we
        && pack_wr_o.idx == 3'h0
        && pack_wr_o.data[7:0] == $past(pack_str_i.chars[7:0], 2))
        else $error("packer first word wrong");
endmodule

bind acu_top acu_chk u_chk
(
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .pack_en_i(pack_en_i),
    .pack_str_i(pack_str_i), .dec_en_i(dec_en_i), .dec_src_i(dec_src_i),
    .enc_en_i(enc_en_i), .enc_src_i(enc_src_i), .fault_clr_i(fault_clr_i),
    .pack_wr_o(pack_wr_o), .pack_ok_o(pack_ok_o), .dec_wr_o(dec_wr_o),
    .dec_ok_o(dec_ok_o), .enc_wr_o(enc_wr_o), .enc_ok_o(enc_ok_o),
    .instruction_fault_flag_o(instruction_fault_flag_o)
);

// ==== testbench/tb_top.sv ====
`timescale 1ns/100ps
`define CHK(a, b, m) begin checked++; if ((a) !== (b)) begin \
    n_errors++; $display("FAIL %0t %s", $time, m); end end
// ****************************************
// Bench
// ****************************************
module tb_top;
    logic               sys_clk_i = 1'b0;
    logic               rst_i = 1'b1;
    logic               pack_en_i = 1'b0;
    acu_pkg::acu_str_t  pack_str_i = '0;
    logic               dec_en_i = 1'b0;
    logic [15:0]        dec_src_i = 16'h0000;
    logic               enc_en_i = 1'b0;
    logic [15:0]        enc_src_i = 16'h0000;
    logic               fault_clr_i = 1'b0;
    logic               fill = 1'b0;
    acu_pkg::acu_wr_t   pack_wr_o;
    acu_pkg::acu_word_t dec_wr_o;
    acu_pkg::acu_word_t enc_wr_o;
    logic               pack_ok_o;
    logic               dec_ok_o;
    logic               enc_ok_o;
    logic               instruction_fault_flag_o;
    logic [15:0]        mem [8];
    int                 n_errors = 0;
    int                 checked = 0;
    bit                 flag = 1'b0;
    int                 cnts [5] = '{0, 1, 14, 16, 17};
    initial
    begin
        forever #50 sys_clk_i = ~sys_clk_i;
    end
    acu_top uut
    (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .pack_en_i(pack_en_i),
        .pack_str_i(pack_str_i), .dec_en_i(dec_en_i), .dec_src_i(dec_src_i),
        .enc_en_i(enc_en_i), .enc_src_i(enc_src_i), .fault_clr_i(fault_clr_i),
        .pack_wr_o(pack_wr_o), .pack_ok_o(pack_ok_o), .dec_wr_o(dec_wr_o),
        .dec_ok_o(dec_ok_o), .enc_wr_o(enc_wr_o), .enc_ok_o(enc_ok_o),
        .instruction_fault_flag_o(instruction_fault_flag_o)
    );
    acu_dst_mem u_mem (.sys_clk_i(sys_clk_i), .fill_i(fill),
                       .wr_i(pack_wr_o), .mem_o(mem));
    function automatic int bcd(int v);
        return (v / 1000) << 12 | (v / 100 % 10) << 8 | (v / 10 % 10) << 4
               | v % 10;
    endfunction
    task automatic tick();
        @(posedge sys_clk_i);
        #1;
    endtask
    task automatic wrap_up();
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic arith(int n);
        int dv;
        bit db;
        bit eb;
        for (int i = 0; i < n; i++)
        begin
            dec_en_i = 1'($urandom);
            dec_src_i = $urandom_range(1) ? 16'($urandom)
                                          : 16'(bcd($urandom % 10000));
            enc_en_i = 1'($urandom);
            enc_src_i = $urandom_range(1) ? 16'($urandom % 10000)
                                          : 16'($urandom);
            fault_clr_i = ($urandom % 6) == 0;
            db = 1'b0;
            dv = 0;
            for (int k = 3; k >= 0; k--)
            begin
                db = db | (dec_src_i[4*k+:4] > 9);
                dv = dv * 10 + dec_src_i[4*k+:4];
            end
            eb = enc_src_i > 9999;
            // Setting wins over a clear in the same cycle
            if ((dec_en_i && db) || (enc_en_i && eb))
                flag = 1'b1;
            else if (fault_clr_i)
                flag = 1'b0;
            tick();
            `CHK({dec_wr_o.we, dec_ok_o}, {2{dec_en_i && !db}}, "dec")
            if (dec_wr_o.we === 1'b1)
                `CHK(dec_wr_o.data, 16'(dv), "dec data")
            `CHK({enc_wr_o.we, enc_ok_o}, {2{enc_en_i && !eb}}, "enc")
            if (enc_wr_o.we === 1'b1)
                `CHK(enc_wr_o.data, 16'(bcd(enc_src_i)), "enc data")
            `CHK(instruction_fault_flag_o, flag, "fault flag")
        end
        {dec_en_i, enc_en_i, fault_clr_i} = 3'h0;
    endtask
    task automatic pack(int cnt, int stop);
        int n;
        int w;
        logic [15:0] e;
        fill = 1'b1;
        tick();
        fill = 1'b0;
        pack_str_i.count = 5'(cnt);
        for (int k = 0; k < 16; k++)
            pack_str_i.chars[8*k+:8] = 8'h41 + 8'($urandom % 26);
        pack_en_i = 1'b1;
        n = (cnt > 16) ? 16 : cnt;
        w = 0;
        if (stop > 0)
        begin
            // Enable dropped mid-string, later words stay untouched
            repeat (stop) tick();
            pack_en_i = 1'b0;
            n = (n > 2 * stop - 2) ? 2 * stop - 2 : n;
        end
        while (stop == 0 && pack_ok_o !== 1'b1 && w < 40)
        begin
            tick();
            w++;
        end
        if (w == 40)
        begin
            n_errors++;
            wrap_up();
        end
        // Ok rises with the last write, the table takes it an edge later
        tick();
        for (int k = 0; k < 8; k++)
        begin
            e = 16'hEEEE;
            if (2 * k < n)
                e[7:0] = pack_str_i.chars[16*k+:8];
            if (2 * k + 1 < n)
                e[15:8] = pack_str_i.chars[16*k+8+:8];
            `CHK(mem[k], e, "pack word")
        end
        pack_en_i = 1'b0;
        tick();
        `CHK(pack_ok_o, 1'b0, "pack ok idle")
    endtask
    initial
    begin
        void'($urandom(32'h6ABB9711));
        repeat (3) tick();
        rst_i = 1'b0;
        arith(80);
        $display("arith test done");
        foreach (cnts[i])
            pack(cnts[i], 0);
        pack(14, 3);
        $display("pack test done");
        wrap_up();
    end
endmodule
